// ### core/macrocell_preload_observe.v
// Preload, observe and power-up clear logic for the macrocell registers
`timescale 1ns/1ps
`include "macrocell_map.vh"
module macrocell_preload_observe #(
  parameter NCELL = 16,
  parameter NDED = 4,
  parameter CLEAR_CYCLES = `POWERUP_CLEAR_CYCLES
) (
  input wire clk,
  input wire rst,
  input wire [NDED-1:0] dedIn,
  input wire [NDED-1:0] preloadUseTrue,
  input wire [NDED-1:0] preloadUseComp,
  input wire [NDED-1:0] observeUseTrue,
  input wire [NDED-1:0] observeUseComp,
  input wire clockOrLatchStrobe,
  input wire [NCELL-1:0] ioIn,
  input wire [NCELL-1:0] logicD,
  input wire [NCELL-1:0] normalOe,
  input wire [NCELL-1:0] activeLow,
  output reg [NCELL-1:0] ioOut,
  output reg [NCELL-1:0] ioOe,
  output wire [NCELL-1:0] regQ,
  output wire preloadMode,
  output wire observeMode,
  output wire clearDone
);

  ////////////////////////////////////////////////////////////////////////
  // Pin mode codes; observe outranks preload when both terms are true
  localparam [1:0] MODE_NORMAL = 2'h0;
  localparam [1:0] MODE_PRELOAD = 2'h1;
  localparam [1:0] MODE_OBSERVE = 2'h2;

  // Bank value that the power-up clear forces into every register
  localparam [NCELL-1:0] CLEAR_BANK = {NCELL{`REG_RESET_VALUE}};

  // Bits needed to hold a count up to the given limit
  function integer bitsFor;
    input integer limit;
    integer rest;
    begin
      bitsFor = 1;
      rest = limit;
      while (rest > 1) begin
        bitsFor = bitsFor + 1;
        rest = rest / 2;
      end
    end
  endfunction

  // Pin level of a register bank after the per-cell polarity
  function [NCELL-1:0] pinLevel;
    input [NCELL-1:0] bank;
    input [NCELL-1:0] invert;
    begin
      pinLevel = bank ^ invert;
    end
  endfunction

  // Pin mode from the two global terms, observe first
  function [1:0] modeOf;
    input preload;
    input observe;
    begin
      if (observe) begin
        modeOf = MODE_OBSERVE;
      end else if (preload) begin
        modeOf = MODE_PRELOAD;
      end else begin
        modeOf = MODE_NORMAL;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Global product terms built from dedicated inputs only
  wire preloadTerm;
  wire observeTerm;

  term_and #(.WIDTH(NDED)) uPreload (
    .inBits(dedIn),
    .useTrue(preloadUseTrue),
    .useComp(preloadUseComp),
    .termOut(preloadTerm)
  );

  term_and #(.WIDTH(NDED)) uObserve (
    .inBits(dedIn),
    .useTrue(observeUseTrue),
    .useComp(observeUseComp),
    .termOut(observeTerm)
  );

  // Modes track the terms combinationally, no latching of entry
  assign preloadMode = preloadTerm;
  assign observeMode = observeTerm;

  ////////////////////////////////////////////////////////////////////////
  // Power-up clear counter; registers stay cleared until it expires
  localparam CW = bitsFor(CLEAR_CYCLES);
  // Last count of the clear, held at the counter's width
  localparam [CW-1:0] CLEAR_LAST = CLEAR_CYCLES[CW-1:0] - 1'b1;
  reg [CW-1:0] clearCnt_ff;
  reg clearDone_ff;
  reg [CW-1:0] nxt_clearCnt;
  reg nxt_clearDone;

  // Next value of the clear counter
  always @* begin
    nxt_clearCnt = clearCnt_ff;
    nxt_clearDone = clearDone_ff;
    if (!clearDone_ff) begin
      if (clearCnt_ff >= CLEAR_LAST) begin
        nxt_clearDone = 1'b1;
      end else begin
        nxt_clearCnt = clearCnt_ff + 1'b1;
      end
    end
  end

  // Clear counter registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      clearCnt_ff <= {CW{1'b0}};
      clearDone_ff <= 1'b0;
    end else begin
      clearCnt_ff <= nxt_clearCnt;
      clearDone_ff <= nxt_clearDone;
    end
  end

  // Clear status seen by the tester
  assign clearDone = clearDone_ff;

  ////////////////////////////////////////////////////////////////////////
  // Strobe rising edge detect; the strobe is sampled as synchronous
  reg strobe_ff;
  wire strobeRise;

  // Previous strobe level
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      strobe_ff <= 1'b0;
    end else begin
      strobe_ff <= clockOrLatchStrobe;
    end
  end

  // Rising edge of the pin clock; idle low matches the reset value
  assign strobeRise = clockOrLatchStrobe & ~strobe_ff;

  ////////////////////////////////////////////////////////////////////////
  // Macrocell registers
  reg [NCELL-1:0] q_ff;
  reg [NCELL-1:0] nxt_q;

  // Preload takes the pin value, otherwise the array result on the edge
  always @* begin
    nxt_q = q_ff;
    if (!clearDone_ff) begin
      nxt_q = CLEAR_BANK;
    end else if (strobeRise) begin
      if (preloadMode) begin
        nxt_q = ioIn;
      end else begin
        nxt_q = logicD;
      end
    end
  end

  // Register bank, cleared LOW at reset
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      q_ff <= CLEAR_BANK;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Register contents straight from the bank
  assign regQ = q_ff;

  ////////////////////////////////////////////////////////////////////////
  // Output drive; observe overrides every enable, preload releases pins
  wire [1:0] pinMode;
  reg [NCELL-1:0] nxt_ioOut;
  reg [NCELL-1:0] nxt_ioOe;

  // Mode that decides the pins this cycle
  assign pinMode = modeOf(preloadMode, observeMode);

  // Next pin drive and enable
  always @* begin
    case (pinMode)
      MODE_OBSERVE: begin
        nxt_ioOut = q_ff;
        nxt_ioOe = {NCELL{1'b1}};
      end
      MODE_PRELOAD: begin
        nxt_ioOut = pinLevel(q_ff, activeLow);
        nxt_ioOe = {NCELL{1'b0}};
      end
      default: begin
        nxt_ioOut = pinLevel(q_ff, activeLow);
        nxt_ioOe = normalOe;
      end
    endcase
  end

  // Pin drive registers, one cycle after the mode change
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ioOut <= {NCELL{1'b0}};
      ioOe <= {NCELL{1'b0}};
    end else begin
      ioOut <= nxt_ioOut;
      ioOe <= nxt_ioOe;
    end
  end

endmodule

// ### core/macrocell_map.vh
// Constants for the macrocell preload and observe logic
`ifndef MACROCELL_MAP_VH
`define MACROCELL_MAP_VH

// Clock period in ns
`define CLK_PERIOD_NS 10
// Power-up clear time in us, and the cycle count derived from it
`define POWERUP_CLEAR_TIME_US 10
`define POWERUP_CLEAR_CYCLES ((`POWERUP_CLEAR_TIME_US * 1000) / `CLK_PERIOD_NS)
// Observe valid output window in ns
`define OBSERVE_VALID_MIN_NS 100
`define OBSERVE_VALID_MAX_NS 500
`define OBSERVE_VALID_CYCLES (`OBSERVE_VALID_MAX_NS / `CLK_PERIOD_NS)
// Step delay and preload pulse limits for the tester, in ns
`define STEP_DELAY_MIN_NS 500
`define STEP_DELAY_MAX_NS 5000
`define PRELOAD_PULSE_MIN_NS 250
`define PRELOAD_PULSE_MAX_NS 700
// Register reset value
`define REG_RESET_VALUE 1'b0

`endif

// ### core/term_and.v
// Wide AND product term over true and complement dedicated inputs
`timescale 1ns/1ps
module term_and #(
  parameter WIDTH = 4
) (
  input wire [WIDTH-1:0] inBits,
  input wire [WIDTH-1:0] useTrue,
  input wire [WIDTH-1:0] useComp,
  output wire termOut
);
  // A literal passes when unconnected; both connected forces false
  assign termOut = &((~useTrue | inBits) & (~useComp | ~inBits));
endmodule

// ### bench/mpo_props.sv
// Assertions on the test-mode pins
`timescale 1ns/1ps
module mpo_props #(parameter CLEAR_CYCLES = 8) (
  input wire clk,
  input wire rst,
  input wire clockOrLatchStrobe,
  input wire [15:0] ioIn,
  input wire [15:0] ioOut,
  input wire [15:0] ioOe,
  input wire [15:0] regQ,
  input wire preloadMode,
  input wire observeMode,
  input wire clearDone
);
  int waitCnt_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence take_s;
    clearDone && preloadMode && $rose(clockOrLatchStrobe);
  endsequence
  // Counts cycles before the clear finishes
  always @(posedge clk or posedge rst) waitCnt_ff <= rst ? 0 : waitCnt_ff + !clearDone;
  a_observe_all_on: assert property (observeMode |=> &ioOe) else $error("oe");
  a_observe_shows_q: assert property (observeMode |=> ioOut == $past(regQ))
    else $error("oq");
  a_preload_frees: assert property (preloadMode && !observeMode |=> !ioOe)
    else $error("pf");
  a_preload_loads: assert property (take_s |=> regQ == $past(ioIn)) else $error("pl");
  a_quiet_keeps_q: assert property (!$rose(clockOrLatchStrobe) |=> $stable(regQ))
    else $error("kq");
  a_clear_low: assert property (!clearDone |-> regQ == 16'h0) else $error("cl");
  a_clear_stays: assert property (clearDone |=> clearDone) else $error("cs");
  a_clear_bound: assert property (waitCnt_ff <= CLEAR_CYCLES + 2) else $error("cb");
endmodule

bind macrocell_preload_observe mpo_props #(.CLEAR_CYCLES(CLEAR_CYCLES)) mpo_props_inst (
  .clk(clk), .rst(rst), .clockOrLatchStrobe(clockOrLatchStrobe), .ioIn(ioIn),
  .ioOut(ioOut), .ioOe(ioOe), .regQ(regQ), .preloadMode(preloadMode),
  .observeMode(observeMode), .clearDone(clearDone));

// ### bench/pin_tester.sv
// Tester model for the preload and observe steps
`timescale 1ns/1ps
module pin_tester (
  input wire clk,
  output logic [3:0] ded,
  output logic [15:0] pins,
  output logic strobe
);
  logic [15:0] last = 16'h0;
  logic drive = 1'b0;
  // Released pins show the inverse of the last value
  assign pins = drive ? last : ~last;
  // Strobe idles low, so latched cells stay non-transparent
  initial {ded, strobe} = 5'h0;
  // Holds each step for 0.5 us
  task automatic step;
    repeat (50) @(posedge clk);
  endtask
  task automatic apply(input logic [3:0] v);
    @(posedge clk);
    ded <= v;
    step();
  endtask
  // Clock pulse of 500 ns
  task automatic pulse;
    strobe <= 1'b1;
    step();
    strobe <= 1'b0;
    step();
  endtask
  // Condition, data, pulse, release, condition off
  task automatic preload(input logic [15:0] v);
    apply(4'h1);
    last <= v;
    drive <= 1'b1;
    step();
    pulse();
    drive <= 1'b0;
    step();
    apply(4'h0);
  endtask
endmodule

// ### bench/macrocell_preload_observe_tb.sv
// Testbench for the preload, observe and clear logic
`timescale 1ns/1ps
module macrocell_preload_observe_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] logicD = 16'h1234;
  logic [15:0] normalOe = 16'hf0f0;
  logic [15:0] activeLow = 16'h00ff;
  logic [3:0] preloadUseTrue = 4'h1;
  logic [3:0] preloadUseComp = 4'h0;
  logic [3:0] observeUseTrue = 4'h2;
  logic [3:0] observeUseComp = 4'h0;
  logic [15:0] pins, ioOut, ioOe, regQ;
  logic [3:0] ded;
  logic strobe, preloadMode, observeMode, clearDone;
  int bad_count = 0;
  int check_count = 0;
  initial begin
    forever #5 clk = ~clk;
  end
  pin_tester pin_tester_inst (.clk(clk), .ded(ded), .pins(pins), .strobe(strobe));
  macrocell_preload_observe #(.CLEAR_CYCLES(8)) macrocell_preload_observe_inst (
    .clk(clk), .rst(rst), .dedIn(ded), .preloadUseTrue(preloadUseTrue),
    .preloadUseComp(preloadUseComp), .observeUseTrue(observeUseTrue),
    .observeUseComp(observeUseComp), .clockOrLatchStrobe(strobe),
    .ioIn(pins), .logicD(logicD), .normalOe(normalOe), .activeLow(activeLow),
    .ioOut(ioOut), .ioOe(ioOe), .regQ(regQ), .preloadMode(preloadMode),
    .observeMode(observeMode), .clearDone(clearDone));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic clear_test;
    int n = 0;
    while (clearDone !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n == 100) begin
      bad_count++;
      tally_and_finish();
    end
    chk("regQ", 16'h0, regQ);
    chk("ioOut", activeLow, ioOut);
    $display("clear test ends");
  endtask
  task automatic preload_test;
    pin_tester_inst.preload(16'ha5c3);
    @(negedge clk);
    chk("regQ", 16'ha5c3, regQ);
    chk("ioOut", 16'ha5c3 ^ activeLow, ioOut);
    $display("preload test ends");
  endtask
  task automatic observe_test;
    pin_tester_inst.apply(4'h2);
    @(negedge clk);
    chk("observeMode", 16'h1, observeMode);
    chk("ioOe", 16'hffff, ioOe);
    chk("ioOut", 16'ha5c3, ioOut);
    pin_tester_inst.apply(4'h0);
    @(negedge clk);
    chk("ioOe", normalOe, ioOe);
    chk("ioOut", 16'ha5c3 ^ activeLow, ioOut);
    $display("observe test ends");
  endtask
  task automatic normal_test;
    @(posedge clk);
    normalOe <= 16'h0ff0;
    logicD <= 16'h5e21;
    activeLow <= 16'h0f0f;
    pin_tester_inst.pulse();
    @(negedge clk);
    chk("regQ", 16'h5e21, regQ);
    chk("ioOe", 16'h0ff0, ioOe);
    chk("ioOut", 16'h512e, ioOut);
    $display("normal test ends");
  endtask
  task automatic term_test;
    @(posedge clk);
    observeUseComp <= 4'h2;
    pin_tester_inst.apply(4'h2);
    @(negedge clk);
    chk("observeMode", 16'h0, observeMode);
    @(posedge clk);
    observeUseComp <= 4'h8;
    repeat (2) @(negedge clk);
    chk("observeMode", 16'h1, observeMode);
    chk("ioOut", 16'h5e21, ioOut);
    pin_tester_inst.apply(4'h0);
    observeUseComp <= 4'h0;
    preloadUseTrue <= 4'h0;
    preloadUseComp <= 4'h4;
    repeat (2) @(negedge clk);
    chk("preloadMode", 16'h1, preloadMode);
    chk("ioOe", 16'h0, ioOe);
    @(posedge clk);
    preloadUseTrue <= 4'h1;
    preloadUseComp <= 4'h0;
    repeat (2) @(negedge clk);
    chk("preloadMode", 16'h0, preloadMode);
    chk("ioOe", 16'h0ff0, ioOe);
    $display("term test ends");
  endtask
  task automatic reset_test;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("clearDone", 16'h0, clearDone);
    chk("regQ", 16'h0, regQ);
    clear_test();
    $display("reset test ends");
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    clear_test();
    preload_test();
    observe_test();
    normal_test();
    term_test();
    reset_test();
    tally_and_finish();
  end
endmodule
